// *** dv/wet_channel_tb.sv ***
`timescale 1ns/1ns
module wet_channel_tb;
  typedef struct packed {
    logic [3:0] code;
    logic [21:0] dly;
    logic [7:0] cal;
    logic [7:0] ofs;
    logic [4:0] act; // Data, drive, load, strobe, window
  } wet_row_t;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic drive_period_start = 1'b0;
  logic compare_period_start = 1'b0;
  logic [7:0] input_delay = 8'h00;
  logic [3:0][7:0] cal_delay = '0;
  logic [3:0] start_sel = 4'h0;
  logic [7:0] comp_lag = 8'h04;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [7:0] host_addr = 8'h00;
  logic push = 1'b0;
  logic [7:0] push_word = 8'h00;
  wet_pkg::wet_entry_t host_wdata = '0;
  wet_pkg::wet_entry_t host_rdata;
  wet_pkg::wet_edge_t [3:0] edge_out;
  logic [7:0] pattern_word;
  logic pattern_word_valid, pattern_ready, host_rvalid, drive_data, drive_en, load_en;
  logic [3:0] strobe;
  logic [3:0][1:0] strobe_kind;
  logic [1:0] window_open, window_close;
  logic [1:0][1:0] window_kind;
  int sent;
  int failures = 0;
  int n_checks = 0;
  // Codes in an order where each drive action shows a change
  wet_row_t rows [15] = '{
    '{4'h2, 22'h000000, 8'h00, 8'h00, 5'b10000}, '{4'h3, 22'h00003F, 8'h00, 8'h00, 5'b10100},
    '{4'h6, 22'h000100, 8'h1F, 8'h02, 5'b11100}, '{4'h5, 22'h0000C0, 8'h40, 8'h00, 5'b01000},
    '{4'h4, 22'h3FFFFF, 8'hFF, 8'hFF, 5'b11000}, '{4'h1, 22'h000055, 8'h00, 8'h0A, 5'b01000},
    '{4'h7, 22'h000000, 8'h00, 8'h00, 5'b01000}, '{4'h8, 22'h000010, 8'h10, 8'h10, 5'b01010},
    '{4'h9, 22'h000280, 8'h00, 8'h21, 5'b01010}, '{4'hA, 22'h000001, 8'h80, 8'h00, 5'b01010},
    '{4'hB, 22'h000300, 8'h00, 8'h00, 5'b01010}, '{4'hC, 22'h000040, 8'h00, 8'h00, 5'b01001},
    '{4'hD, 22'h000000, 8'h7F, 8'h01, 5'b01001}, '{4'hE, 22'h000123, 8'h00, 8'h00, 5'b01001},
    '{4'hF, 22'h000000, 8'h00, 8'h00, 5'b01001}};
  wet_channel dut_u (.mclk(mclk), .arst_n(arst_n), .pattern_word(pattern_word),
    .pattern_word_valid(pattern_word_valid), .pattern_ready(pattern_ready),
    .drive_period_start(drive_period_start), .compare_period_start(compare_period_start),
    .input_delay(input_delay), .cal_delay(cal_delay), .start_sel(start_sel),
    .round_trip_compensation(comp_lag), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .edge_out(edge_out), .drive_data(drive_data),
    .drive_en(drive_en), .load_en(load_en), .strobe(strobe), .strobe_kind(strobe_kind),
    .window_open(window_open), .window_kind(window_kind), .window_close(window_close));
  wet_pat_src src_u (.mclk(mclk), .arst_n(arst_n), .push(push), .push_word(push_word),
    .pattern_ready(pattern_ready), .pattern_word(pattern_word),
    .pattern_word_valid(pattern_word_valid), .sent(sent));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [103:0] seen, input logic [103:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    failures++;
    $display("[FAIL] %s wait ran out", what);
    report_and_stop();
  endtask
  task automatic hwrite(input logic [7:0] a, input wet_pkg::wet_entry_t d);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    step();
    host_wr = 1'b0;
  endtask
  task automatic feed(input logic [7:0] w, input int k);
    push = 1'b1;
    push_word = w;
    repeat (k) step();
    push = 1'b0;
  endtask
  // Bounded wait for the source to hand over its words
  task automatic wait_sent(input int tgt);
    for (int i = 0; i < 100 && sent != tgt; i++) step();
    if (sent != tgt) hang("feed");
    step();
  endtask
  // Period start, then count cycles to the edge; compare start at cycle cps
  task automatic run_pop(input int g, input int cps, output int n);
    drive_period_start = 1'b1;
    step();
    drive_period_start = 1'b0;
    for (n = 1; n < 20000; n++) begin
      compare_period_start = (n == cps);
      if (edge_out[g].fire === 1'b1) break;
      step();
    end
    compare_period_start = 1'b0;
    if (n == 20000) hang("edge");
  endtask
  task automatic chk_rst();
    chk("reset_outs", {pattern_ready, drive_data, drive_en, load_en, strobe, window_open,
      window_close, host_rvalid}, 13'h1000);
    chk("reset_edges", edge_out, '0);
  endtask
  initial begin
    int n;
    logic [23:0] sum;
    wet_pkg::wet_entry_t e;
    repeat (5) @(posedge mclk);
    #1;
    chk_rst();
    $display("test reset_start done");
    arst_n = 1'b1;
    step();
    // Table rows, each on generator zero
    for (int i = 0; i < 15; i++) begin
      e = '0;
      e[0] = {rows[i].dly, rows[i].code};
      hwrite(8'(i), e);
      cal_delay[0] = rows[i].cal;
      input_delay = rows[i].ofs;
      feed(8'(i), 1);
      wait_sent(i + 1);
      run_pop(0, 0, n);
      sum = 24'(rows[i].dly) + 24'(rows[i].cal) + 24'(rows[i].ofs);
      if (rows[i].code >= 4'h7) sum = sum + 24'({comp_lag, 6'h00});
      chk("fire_cycle", 104'(n), 104'(sum[23:8]) + 104'd3);
      chk("phase", edge_out[0].phase, sum[7:6]);
      chk("vernier", edge_out[0].vern, (sum[5:0] * 12'd60 + 12'd32) >> 6);
      chk("actions", {drive_data, drive_en, load_en, strobe[0], window_open[0]},
        rows[i].act);
      if (rows[i].act[1]) chk("strobe_kind", strobe_kind[0], rows[i].code[1:0]);
      if (rows[i].act[0]) chk("window_kind", window_kind[0], rows[i].code[1:0]);
      hwrite(8'h80, '0);
      host_rd = 1'b1;
      host_addr = 8'(i);
      step();
      host_rd = 1'b0;
      chk("host_read", host_rdata, e);
      chk("host_rvalid", host_rvalid, 1'b1);
    end
    $display("test rows done");
    // Period start on an empty buffer; idle word must be ignored
    drive_period_start = 1'b1;
    step();
    drive_period_start = 1'b0;
    n = 0;
    repeat (20) begin
      step();
      if (edge_out[0].fire !== 1'b0) n++;
    end
    chk("idle_fires", 104'(n), 104'd0);
    $display("test idle done");
    // Both windows opened on even edges, closed by odd edges
    e = {{22'h000100, 4'h7}, {22'h000000, 4'hD}, {22'h000100, 4'h7}, {22'h000000, 4'hC}};
    hwrite(8'hF0, e);
    cal_delay = '0;
    input_delay = 8'h00;
    feed(8'hF0, 1);
    wait_sent(16);
    run_pop(3, 0, n);
    chk("close_cycle", 104'(n), 104'd5);
    chk("window_ends", {window_close, window_open}, 4'hC);
    chk("window_kind1", window_kind[1], 2'h1);
    $display("test windows done");
    // Edge timed from the compare period start
    e = '0;
    e[0] = {22'h000000, 4'h2};
    hwrite(8'hF1, e);
    start_sel = 4'h1;
    feed(8'hF1, 1);
    wait_sent(17);
    run_pop(0, 5, n);
    chk("sel_cycle", 104'(n), 104'd7);
    chk("sel_drive", drive_data, 1'b1);
    start_sel = 4'h0;
    $display("test start_sel done");
    // Fill the buffer past its depth, then drain back to back
    feed(8'hF1, 33);
    for (int i = 0; i < 100 && pattern_ready === 1'b1; i++) step();
    repeat (3) step();
    chk("fill_taken", 104'(sent), 104'd49);
    chk("fill_ready", pattern_ready, 1'b0);
    drive_period_start = 1'b1;
    repeat (40) step();
    drive_period_start = 1'b0;
    wait_sent(50);
    repeat (10) step();
    chk("drain_ready", pattern_ready, 1'b1);
    $display("test fill done");
    // Reset in mid-flight clears pending edges
    feed(8'hF0, 1);
    wait_sent(51);
    drive_period_start = 1'b1;
    step();
    drive_period_start = 1'b0;
    arst_n = 1'b0;
    #2;
    chk_rst();
    step();
    arst_n = 1'b1;
    n = 0;
    repeat (10) begin
      step();
      if (edge_out[0].fire !== 1'b0) n++;
    end
    chk("post_reset_fires", 104'(n), 104'd0);
    $display("test reset done");
    report_and_stop();
  end
endmodule

// *** dv/wet_checker.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checks for one timing channel
// ------------------------------------------------------------
module wet_checker (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset
  input wire logic pattern_word_valid, // Offer
  input wire logic pattern_ready, // Room
  input wire logic host_rd, // Host read
  input wire logic host_rvalid, // Read done
  input wire wet_pkg::wet_edge_t [3:0] edge_out, // Edges
  input wire logic drive_data, // Level
  input wire logic drive_en, // Driver on
  input wire logic load_en, // Load on
  input wire logic [3:0] strobe, // Strobes
  input wire logic [1:0] window_open, // Windows
  input wire logic [1:0] window_close // Closes
);
  logic [3:0] fires; // One bit per generator
  logic took; // Some word was accepted
  logic next_took;
  assign fires = {edge_out[3].fire, edge_out[2].fire, edge_out[1].fire, edge_out[0].fire};
  // Sticky acceptance flag; an edge with no word behind it is invented
  always_comb begin
    next_took = took || (pattern_word_valid && pattern_ready);
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      took <= 1'b0;
    end else begin
      took <= next_took;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_rd_req; host_rd; endsequence
  sequence s_rd_ans; host_rvalid; endsequence
  property p_rd_answer; s_rd_req |=> s_rd_ans; endproperty
  property p_rd_only; s_rd_ans |-> $past(host_rd); endproperty
  property p_strobe_fire; (strobe & ~fires) == 4'h0; endproperty
  property p_open_even; $rose(window_open[0]) |-> fires[0]; endproperty
  property p_close_0; window_close[0] |-> fires[1] && $past(window_open[0]); endproperty
  property p_close_1; window_close[1] |-> fires[3] && $past(window_open[1]); endproperty
  property p_drive_cause; !$stable({drive_data, drive_en, load_en}) |-> fires != 4'h0; endproperty
  property p_word_first; fires != 4'h0 |-> took; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("host read unanswered");
  a_rd_only: assert property (p_rd_only) else $error("stray host read data");
  a_strobe_fire: assert property (p_strobe_fire) else $error("strobe without edge");
  a_open_even: assert property (p_open_even) else $error("window opened off edge zero");
  a_close_0: assert property (p_close_0) else $error("window zero close bad");
  a_close_1: assert property (p_close_1) else $error("window one close bad");
  a_drive_cause: assert property (p_drive_cause) else $error("drive moved without edge");
  a_word_first: assert property (p_word_first) else $error("edge with no word taken");
endmodule
bind wet_channel wet_checker ck_u (.mclk, .arst_n, .pattern_word_valid, .pattern_ready,
  .host_rd, .host_rvalid, .edge_out, .drive_data, .drive_en, .load_en, .strobe,
  .window_open, .window_close);

// *** dv/wet_pat_src.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Pattern source model feeding the channel
// ------------------------------------------------------------
module wet_pat_src (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset
  input wire logic push, // Queue a word
  input wire logic [7:0] push_word, // Word to queue
  input wire logic pattern_ready, // Room
  output logic [7:0] pattern_word, // Word out
  output logic pattern_word_valid, // Offer
  output int sent // Words taken
);
  logic [7:0] q[$];
  // Offer held until taken; idle word toggles so it is never trusted
  // packing opaque, plain index
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_word_valid <= 1'b0;
      pattern_word <= 8'h00;
      sent <= 0;
      q.delete();
    end else begin
      if (pattern_word_valid && pattern_ready) begin
        void'(q.pop_front());
        sent <= sent + 1;
      end
      if (push) q.push_back(push_word);
      pattern_word_valid <= (q.size() != 0);
      pattern_word <= (q.size() != 0) ? q[0] : ~pattern_word;
    end
  end
endmodule

// *** include/wet_pkg.sv ***
// ------------------------------------------------------------
// Waveform event timing: shared constants and types
// ------------------------------------------------------------
package wet_pkg;

  // Geometry of one channel
  localparam int EV_N = 4;
  localparam int PAT_W = 8;
  localparam int WAVES = 256;
  localparam int DLY_W = 22;
  localparam int CODE_W = 4;
  localparam int OFS_W = 8;
  localparam int LAG_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int SLOTS = 4;

  // Delay sum layout: clocks, 2.5 ns phase, vernier
  localparam int SUM_W = 24;
  localparam int VERN_W = 6;
  localparam int PH_W = 2;
  localparam int PH_LSB = VERN_W;
  localparam int CNT_LSB = VERN_W + PH_W;
  localparam int CNT_W = SUM_W - CNT_LSB;
  localparam int VSTEPS = 60;

  // Timing: 2.5 ns step against the 10 ns master clock
  localparam int CLK_PS = 10000;
  localparam int STEP_PS = 2500;
  localparam int STEPS_PER_CLK = CLK_PS / STEP_PS;

  // Event actions, fixed one-to-one encoding
  typedef enum logic [3:0] {
    CD_N  = 4'h0, CD_LO = 4'h1, CD_HI = 4'h2, CD_Z  = 4'h3,
    CD_U  = 4'h4, CD_D  = 4'h5, CD_P  = 4'h6, CD_X  = 4'h7,
    CD_L  = 4'h8, CD_H  = 4'h9, CD_T  = 4'hA, CD_V  = 4'hB,
    CD_LW = 4'hC, CD_HW = 4'hD, CD_TW = 4'hE, CD_VW = 4'hF
  } wet_code_t;

  // One 26-bit event slot of a waveform entry
  typedef struct packed {
    logic [DLY_W-1:0] delay;
    logic [CODE_W-1:0] code;
  } wet_event_t;

  // One 104-bit waveform entry: four events
  typedef wet_event_t [EV_N-1:0] wet_entry_t;

  // Edge handed to the analog delay line
  typedef struct packed {
    logic fire;
    logic [PH_W-1:0] phase;
    logic [VERN_W-1:0] vern;
  } wet_edge_t;

  // One pending edge of a generator
  typedef struct packed {
    logic busy;
    logic arm;
    logic [CODE_W-1:0] code;
    logic [CNT_W-1:0] cnt;
    logic [PH_W-1:0] phase;
    logic [VERN_W-1:0] vern;
  } wet_slot_t;

  // Compare-class codes, including the don't-care close
  function automatic logic is_compare(input logic [CODE_W-1:0] c);
    return c >= CD_X;
  endfunction

  // Binary vernier to one of sixty steps, rounded
  function automatic logic [VERN_W-1:0] vern_map(input logic [VERN_W-1:0] v);
    logic [9:0] t;
    t = 10'(v) * 10'h00F + 10'h008;
    return t[9:4];
  endfunction

endpackage

// *** logic/wet_channel.sv ***
`timescale 1ns/1ns
// Function
// - Pattern word indexes one of 256 waveform entries.
// - Entry holds 26 bits per event, 104 bits total.
// - Event slot is 22-bit delay plus 4-bit code.
// - Memory has a second port for host access mid-burst.
// - Only valid pattern words are used; else no events.
// - Four generators take delay, code and 8-bit offset.
// - Delay spans four periods, about 163 us, 39.06 ps step.
// - Sixteen event actions chosen by the event code.
// - Compare events delayed by round-trip count, 2.5 ns steps.
// - Each generator starts from drive or compare period start.
// - Delay is memory delay plus calibration plus global offset.
// - Delay is 2.5 ns counts plus a 6-bit vernier fraction.
// - Code N does nothing; 0 drives low, 1 drives high.
// - Code Z turns driver off and load on.
// - U and D force level with driver on; P enables driver.
// - L, H, T, V strobe low, high, midband, valid.
// - X is don't-care and may close a window.
// - l, h, t, v open a window of that level.
// - Active-low reset holds the block in reset.
// - Edge 0 opens, edge 1 closes; edges 2 and 3 likewise.
// - Vernier maps to sixty steps, rounding code times 60/64.
module wet_channel (
  input wire logic mclk, // Master clock, 100 MHz
  input wire logic arst_n, // Power-on reset
  input wire logic [7:0] pattern_word, // Waveform index
  input wire logic pattern_word_valid, // Word qualifier
  output logic pattern_ready, // Buffer has room
  input wire logic drive_period_start, // Drive period pulse
  input wire logic compare_period_start, // Compare period pulse
  input wire logic [7:0] input_delay, // Global offset
  input wire logic [3:0][7:0] cal_delay, // Per-edge calibration
  input wire logic [3:0] start_sel, // 1: compare start
  input wire logic [7:0] round_trip_compensation, // Compare lag
  input wire logic host_wr, // Host write
  input wire logic host_rd, // Host read
  input wire logic [7:0] host_addr, // Host index
  input wire wet_pkg::wet_entry_t host_wdata, // Host entry in
  output wet_pkg::wet_entry_t host_rdata, // Host entry out
  output logic host_rvalid, // Host read done
  output wet_pkg::wet_edge_t [3:0] edge_out, // Edge to vernier
  output logic drive_data, // Driver level
  output logic drive_en, // Driver enable
  output logic load_en, // Load enable
  output logic [3:0] strobe, // Edge compare pulse
  output logic [3:0][1:0] strobe_kind, // Expected level
  output logic [1:0] window_open, // Window level
  output logic [1:0][1:0] window_kind, // Window expectation
  output logic [1:0] window_close // Window end pulse
);
  // ------------------------------------------------------------
  // Pattern buffer and waveform lookup
  // ------------------------------------------------------------
  logic buf_valid;
  logic [7:0] buf_word;
  logic pop;
  logic look;
  wet_pkg::wet_entry_t wave;

  // Invalid words never enter, so they cause no events
  // valid qualifies word
  wet_fifo #(
    .W(wet_pkg::PAT_W),
    .DEPTH(wet_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(pattern_word_valid),
    .in_ready(pattern_ready),
    .in_data(pattern_word),
    .out_valid(buf_valid),
    .out_ready(drive_period_start),
    .out_data(buf_word)
  );

  // One word per drive period; the source stalls when full
  // A compare period start never drains the buffer
  assign pop = drive_period_start && buf_valid;

  wet_wave_mem u_mem (
    .mclk(mclk),
    .arst_n(arst_n),
    .a_en(pop),
    .a_addr(buf_word),
    .a_data(wave),
    .b_wr(host_wr),
    .b_rd(host_rd),
    .b_addr(host_addr),
    .b_wdata(host_wdata),
    .b_rdata(host_rdata),
    .b_rvalid(host_rvalid)
  );

  // Entry is on the read port one cycle after the pop
  // Loading slots on the pop itself would read a stale entry
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      look <= 1'b0;
    end else begin
      look <= pop;
    end
  end

  // ------------------------------------------------------------
  // Delay generators
  // ------------------------------------------------------------
  wet_pkg::wet_slot_t slot [4][4];
  wet_pkg::wet_slot_t next_slot [4][4];
  logic [1:0] wptr [4];
  logic [1:0] next_wptr [4];
  wet_pkg::wet_edge_t [3:0] next_edge;
  logic [3:0] fire_code [4];

  // Four slots per edge keep four periods of edges in flight
  // A fifth pending edge on one generator overwrites its oldest slot
  // Sum is latched at lookup; later offset changes leave it alone
  always_comb begin
    logic [wet_pkg::SUM_W-1:0] sum;
    wet_pkg::wet_event_t ev;
    sum = '0;
    ev = '0;
    next_slot = slot;
    next_wptr = wptr;
    next_edge = '0;
    for (int g = 0; g < wet_pkg::EV_N; g++) begin
      fire_code[g] = wet_pkg::CD_N;
      for (int s = 0; s < wet_pkg::SLOTS; s++) begin
        if (slot[g][s].busy) begin
          if (slot[g][s].cnt == '0) begin
            next_slot[g][s].busy = 1'b0;
            next_edge[g] = {1'b1, slot[g][s].phase, slot[g][s].vern};
            fire_code[g] = slot[g][s].code;
          end else begin
            next_slot[g][s].cnt = slot[g][s].cnt - 1'b1;
          end
        end else if (slot[g][s].arm && compare_period_start) begin
          next_slot[g][s].arm = 1'b0;
          next_slot[g][s].busy = 1'b1;
        end
      end
      if (look) begin
        ev = wave[g];
        sum = wet_pkg::SUM_W'(ev.delay) + wet_pkg::SUM_W'(cal_delay[g])
            + wet_pkg::SUM_W'(input_delay);
        if (wet_pkg::is_compare(ev.code)) begin
          sum = sum + (wet_pkg::SUM_W'(round_trip_compensation) << wet_pkg::PH_LSB);
        end
        next_slot[g][wptr[g]].busy = !start_sel[g];
        next_slot[g][wptr[g]].arm = start_sel[g];
        next_slot[g][wptr[g]].code = ev.code;
        next_slot[g][wptr[g]].cnt = sum[wet_pkg::SUM_W-1:wet_pkg::CNT_LSB];
        next_slot[g][wptr[g]].phase = sum[wet_pkg::CNT_LSB-1:wet_pkg::PH_LSB];
        next_slot[g][wptr[g]].vern = wet_pkg::vern_map(sum[wet_pkg::VERN_W-1:0]);
        next_wptr[g] = 2'(wptr[g] + 1'b1);
      end
    end
  end

  // Pending edges are dropped on reset, never replayed
  // reset clears generators
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int g = 0; g < wet_pkg::EV_N; g++) begin
        wptr[g] <= 2'h0;
        for (int s = 0; s < wet_pkg::SLOTS; s++) begin
          slot[g][s] <= '0;
        end
      end
      edge_out <= '0;
    end else begin
      slot <= next_slot;
      wptr <= next_wptr;
      edge_out <= next_edge;
    end
  end

  // ------------------------------------------------------------
  // Event action decode
  // ------------------------------------------------------------
  logic next_data, next_den, next_load;
  logic [3:0] next_strobe;
  logic [3:0][1:0] next_skind;
  logic [1:0] next_wopen, next_wclose;
  logic [1:0][1:0] next_wkind;

  // Code table, four-bit value to action:
  // 0 none, 1 drive low, 2 drive high, 3 driver off and load on
  // 4 force high, 5 force low, 6 driver on only, 7 don't-care compare
  // 8 to B strobe low, high, midband, valid
  // C to F open window low, high, midband, valid on even edges
  // Kind outputs reuse the low two code bits
  // Higher-numbered edge wins on drive, enable and load when two edges hit the same cycle
  // sixteen actions decoded
  always_comb begin
    next_data = drive_data;
    next_den = drive_en;
    next_load = load_en;
    next_strobe = '0;
    next_skind = strobe_kind;
    next_wopen = window_open;
    next_wkind = window_kind;
    next_wclose = '0;
    for (int g = 0; g < wet_pkg::EV_N; g++) begin
      if (next_edge[g].fire) begin
        unique case (wet_pkg::wet_code_t'(fire_code[g]))
          wet_pkg::CD_N: begin
          end
          wet_pkg::CD_LO: begin
            next_data = 1'b0;
          end
          wet_pkg::CD_HI: begin
            next_data = 1'b1;
          end
          wet_pkg::CD_Z: begin
            next_den = 1'b0;
            next_load = 1'b1;
          end
          wet_pkg::CD_U: begin
            next_data = 1'b1;
            next_den = 1'b1;
            next_load = 1'b0;
          end
          wet_pkg::CD_D: begin
            next_data = 1'b0;
            next_den = 1'b1;
            next_load = 1'b0;
          end
          wet_pkg::CD_P: begin
            next_den = 1'b1;
          end
          wet_pkg::CD_X: begin
          end
          wet_pkg::CD_L, wet_pkg::CD_H, wet_pkg::CD_T, wet_pkg::CD_V: begin
            next_strobe[g] = 1'b1;
            next_skind[g] = fire_code[g][1:0];
          end
          wet_pkg::CD_LW, wet_pkg::CD_HW, wet_pkg::CD_TW, wet_pkg::CD_VW: begin
            if (g % 2 == 0) begin
              next_wopen[g/2] = 1'b1;
              next_wkind[g/2] = fire_code[g][1:0];
            end
          end
        endcase
        // Window codes on an odd edge only close, never open
        // Even edges never close, so a window needs its odd partner
        // odd edge closes pair
        if (g % 2 == 1 && window_open[g/2] && wet_pkg::is_compare(fire_code[g])) begin
          next_wopen[g/2] = 1'b0;
          next_wclose[g/2] = 1'b1;
        end
      end
    end
  end

  // Outputs settle in the cycle the edge is handed out
  // Kind levels hold until the next strobe or window of that edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      drive_data <= 1'b0;
      drive_en <= 1'b0;
      load_en <= 1'b0;
      strobe <= '0;
      strobe_kind <= '0;
      window_open <= '0;
      window_kind <= '0;
      window_close <= '0;
    end else begin
      drive_data <= next_data;
      drive_en <= next_den;
      load_en <= next_load;
      strobe <= next_strobe;
      strobe_kind <= next_skind;
      window_open <= next_wopen;
      window_kind <= next_wkind;
      window_close <= next_wclose;
    end
  end
endmodule

// *** logic/wet_fifo.sv ***
`timescale 1ns/1ns
module wet_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk, // Master clock
  input wire logic arst_n, // Async reset
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room left, registered
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word held
  input wire logic out_ready, // Drain side takes
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr, next_rd;
  logic [AW:0] count, next_count;
  logic next_ready, push, pop;

  // ------------------------------------------------------------
  // Pointer and level update
  // ------------------------------------------------------------
  // Ready is precomputed so the port comes from a flop
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
    next_ready = next_count != (AW+1)'(DEPTH);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr <= next_wr;
      rd_ptr <= next_rd;
      count <= next_count;
      in_ready <= next_ready;
    end
  end

  // Storage carries no reset
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
endmodule

// *** logic/wet_wave_mem.sv ***
`timescale 1ns/1ns
module wet_wave_mem (
  input wire logic mclk, // Master clock
  input wire logic arst_n, // Async reset
  input wire logic a_en, // Lookup strobe
  input wire logic [7:0] a_addr, // Lookup index
  output wet_pkg::wet_entry_t a_data, // Entry, next cycle
  input wire logic b_wr, // Host write
  input wire logic b_rd, // Host read
  input wire logic [7:0] b_addr, // Host index
  input wire wet_pkg::wet_entry_t b_wdata, // Host write entry
  output wet_pkg::wet_entry_t b_rdata, // Host read entry
  output logic b_rvalid // Host read done
);
  wet_pkg::wet_entry_t mem [wet_pkg::WAVES];

  // ------------------------------------------------------------
  // Two independent ports
  // ------------------------------------------------------------
  // A lookup racing a host write sees the old entry
  always_ff @(posedge mclk) begin
    if (a_en) begin
      a_data <= mem[a_addr];
    end
    if (b_wr) begin
      mem[b_addr] <= b_wdata;
    end
    if (b_rd) begin
      b_rdata <= mem[b_addr];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      b_rvalid <= 1'b0;
    end else begin
      b_rvalid <= b_rd;
    end
  end
endmodule
